// *** rsss_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module rsss_chk import rsss_pkg::*; (
  input wire logic core_clk_i, reset_i, low_voltage_variant_i, eprom_either_strobe_i, sram_both_spaces_i,
  input wire logic io_register_space_select_i,
  input wire rsss_bus_t bus_i,
  input wire logic [2:0] upper_chip_select_outputs_o, port_c_pins_oe_o, high_address_inputs_oe_o,
  input wire logic signals_valid_o, power_down_o,
  input wire rsss_select_t select_o,
  input wire logic [7:0] io_rdata_o, power_mode_register_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence rel_s; $fell(reset_i); endsequence
  sequence lv_rel_s; rel_s ##0 low_voltage_variant_i; endsequence
  cs_reset_a: assert property (rel_s |-> upper_chip_select_outputs_o == 3'h7) else $error("cs not high");
  lv_float_a: assert property (lv_rel_s |-> port_c_pins_oe_o == 3'h0) else $error("cs driven");
  hi_addr_a: assert property (high_address_inputs_oe_o == 3'h0) else $error("address driven");
  std_valid_a: assert property (rel_s ##0 !low_voltage_variant_i |-> ##[1:2] signals_valid_o) else $error("late");
  lv_wait_a: assert property (lv_rel_s |-> !signals_valid_o [*8]) else $error("early valid");
  io_clear_a: assert property (rel_s |-> io_rdata_o == 8'h00 && power_mode_register_o == 8'h00) else $error("io");
  pd_hold_a: assert property (power_down_o && $past(power_down_o) |-> $stable(power_mode_register_o))
    else $error("io changed");
  eprom_space_a: assert property (select_o.eprom |-> $past(bus_i.program_store_strobe ||
    eprom_either_strobe_i && bus_i.data_read_strobe)) else $error("eprom space");
  sram_space_a: assert property (select_o.sram |-> $past(bus_i.data_read_strobe || bus_i.write_strobe ||
    sram_both_spaces_i && bus_i.program_store_strobe)) else $error("sram space");
  io_space_a: assert property (select_o.io |-> $past(io_register_space_select_i && (bus_i.data_read_strobe ||
    bus_i.write_strobe))) else $error("io space");
  pd_refuse_a: assert property (power_down_o |-> select_o == 3'h0) else $error("pd select");
endmodule : rsss_chk
bind rsss_core rsss_chk u_chk (.*);
`default_nettype wire

// *** rsss_core.sv ***
// Functional notes
// - upper chip selects held high but undriven during reset; push-pull drives them high the cycle after release, low-voltage part floats them.
// - high address pins stay high-impedance inputs during reset and power-down.
// - signals valid at reset end; low-voltage part waits 500 ns more.
// - reset clears every bit of every I/O space register to zero.
// - program memory answers program-store strobe only, or either strobe by option.
// - SRAM and I/O never in program space only; default data space only.
// - an option lets SRAM answer both program and data space accesses.
// - inactive chip-select input disables inputs and forces power-down.
`timescale 1ns/100ps
`default_nettype none
`include "rsss_params.svh"

module rsss_core (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // configuration
  input wire logic low_voltage_variant_i,
  input wire logic upper_cs_push_pull_i,
  input wire logic eprom_either_strobe_i,
  input wire logic sram_both_spaces_i,
  // power-down control, high is inactive
  input wire logic chip_select_in_i,
  // controller bus
  input wire rsss_pkg::rsss_bus_t bus_i,
  input wire logic io_register_space_select_i,
  input wire logic [`RSSS_UPPER_CS_W-1:0] cs_equation_i,
  input wire logic [`RSSS_HIGH_ADDR_W-1:0] high_address_inputs_i,
  // upper chip selects on the port c pins
  output logic [`RSSS_UPPER_CS_W-1:0] upper_chip_select_outputs_o,
  output logic [`RSSS_UPPER_CS_W-1:0] port_c_pins_oe_o,
  output logic [`RSSS_HIGH_ADDR_W-1:0] high_address_inputs_oe_o,
  // status and results
  output logic signals_valid_o,
  output logic power_down_o,
  output rsss_pkg::rsss_select_t select_o,
  output logic [7:0] io_rdata_o,
  output logic [7:0] power_mode_register_o
);
  import rsss_pkg::*;

  rsss_state_t state;
  rsss_state_t next_state;
  logic [`RSSS_CNT_W-1:0] settle_cnt;
  logic [`RSSS_CNT_W-1:0] next_settle_cnt;
  logic [7:0] io_regs [`RSSS_IO_REG_COUNT];
  logic [7:0] next_io_regs [`RSSS_IO_REG_COUNT];
  logic [`RSSS_UPPER_CS_W-1:0] next_cs_out;
  logic [`RSSS_UPPER_CS_W-1:0] next_cs_oe;
  logic [7:0] next_io_rdata;
  rsss_select_t next_select;
  logic next_power_down;
  logic inputs_live;

  assign inputs_live = !chip_select_in_i && (state == RSSS_RUN);

  // reset sequencing
  always_comb begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    unique case (state)
      RSSS_IN_RESET: begin
        next_settle_cnt = '0;
        if (low_voltage_variant_i) begin
          next_state = RSSS_SETTLE;
        end else begin
          next_state = RSSS_RUN;
        end
      end
      RSSS_SETTLE: begin
        next_settle_cnt = settle_cnt + `RSSS_CNT_W'(1);
        if (settle_cnt >= `RSSS_CNT_W'(`RSSS_LV_VALID_CYCLES - 1)) begin
          next_state = RSSS_RUN;
        end
      end
      RSSS_RUN: begin
        next_state = RSSS_RUN;
      end
      default: begin
        next_state = RSSS_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= RSSS_IN_RESET;
      settle_cnt <= '0;
    end else begin
      state <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  // i/o register space; only a bus write changes it
  always_comb begin
    for (int i = 0; i < `RSSS_IO_REG_COUNT; i++) begin
      next_io_regs[i] = io_regs[i];
    end
    if (inputs_live && io_register_space_select_i && bus_i.write_strobe) begin
      next_io_regs[bus_i.io_addr] = bus_i.wdata;
    end
    next_io_rdata = io_regs[bus_i.io_addr];
  end

  genvar g;
  generate
    for (g = 0; g < `RSSS_IO_REG_COUNT; g++) begin : g_io_reg
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          io_regs[g] <= `RSSS_IO_REG_RESET;
        end else begin
          io_regs[g] <= next_io_regs[g];
        end
      end
    end
  endgenerate

  // power-down follows the chip-select input level
  always_comb begin
    next_power_down = chip_select_in_i;
  end

  // upper chip-select pins
  always_comb begin
    next_cs_out = {`RSSS_UPPER_CS_W{1'b1}};
    next_cs_oe = '0;
    if (state == RSSS_IN_RESET) begin
      // low-voltage part leaves the pins floating in reset
      if (upper_cs_push_pull_i && !low_voltage_variant_i) begin
        next_cs_oe = {`RSSS_UPPER_CS_W{1'b1}};
      end else begin
        next_cs_oe = '0;
      end
    end else begin
      // equations still drive the selects during power-down
      next_cs_out = cs_equation_i;
      if (upper_cs_push_pull_i) begin
        next_cs_oe = {`RSSS_UPPER_CS_W{1'b1}};
      end else begin
        // open-drain mode never drives from here
        next_cs_oe = '0;
      end
    end
  end

  // space decode; refused outside run or in power-down
  always_comb begin
    next_select = '0;
    if (inputs_live) begin
      next_select.eprom = bus_i.program_store_strobe ||
        (eprom_either_strobe_i && bus_i.data_read_strobe);
      next_select.sram = bus_i.data_read_strobe || bus_i.write_strobe ||
        (sram_both_spaces_i && bus_i.program_store_strobe);
      // i/o answers data space only, never program space
      next_select.io = io_register_space_select_i &&
        (bus_i.data_read_strobe || bus_i.write_strobe);
    end
  end

  // selects are inactive high while reset is asserted
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      upper_chip_select_outputs_o <= {`RSSS_UPPER_CS_W{1'b1}};
    end else begin
      upper_chip_select_outputs_o <= next_cs_out;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port_c_pins_oe_o <= '0;
    end else begin
      port_c_pins_oe_o <= next_cs_oe;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      power_down_o <= 1'b0;
    end else begin
      power_down_o <= next_power_down;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      select_o <= '0;
    end else begin
      select_o <= next_select;
    end
  end

  // read data lags the address by one edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      io_rdata_o <= `RSSS_IO_REG_RESET;
    end else begin
      io_rdata_o <= next_io_rdata;
    end
  end


  assign high_address_inputs_oe_o = '0;
  assign signals_valid_o = (state == RSSS_RUN);
  assign power_mode_register_o = io_regs[`RSSS_IO_REG_COUNT-1];

endmodule : rsss_core
`default_nettype wire

// *** rsss_mcu.sv ***
`timescale 1ns/100ps
`default_nettype none
module rsss_mcu import rsss_pkg::*; (
  input wire logic core_clk_i,
  input wire logic [1:0] kind_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  output rsss_bus_t bus_o
);
  initial bus_o = '0;
  // idle lines toggle so a stale value never passes
  always @(negedge core_clk_i) begin
    bus_o.program_store_strobe <= kind_i == 2'h1;
    bus_o.data_read_strobe <= kind_i == 2'h2;
    bus_o.write_strobe <= kind_i == 2'h3;
    bus_o.io_addr <= (kind_i != 2'h0) ? addr_i : ~bus_o.io_addr;
    bus_o.wdata <= (kind_i == 2'h3) ? wdata_i : ~bus_o.wdata;
  end
endmodule : rsss_mcu
`default_nettype wire

// *** rsss_params.svh ***
`ifndef RSSS_PARAMS_SVH
`define RSSS_PARAMS_SVH

`define RSSS_CLK_PERIOD_NS 10
`define RSSS_LV_VALID_DELAY_NS 500
// least time, rounded up to whole cycles
`define RSSS_LV_VALID_CYCLES ((`RSSS_LV_VALID_DELAY_NS + `RSSS_CLK_PERIOD_NS - 1) / `RSSS_CLK_PERIOD_NS)
`define RSSS_CNT_W 7
`define RSSS_IO_REG_COUNT 8
`define RSSS_IO_ADDR_W 3
`define RSSS_IO_REG_RESET 8'h00
`define RSSS_UPPER_CS_W 3
`define RSSS_HIGH_ADDR_W 3

`endif

// *** rsss_pkg.sv ***
package rsss_pkg;

  typedef enum logic [2:0] {
    RSSS_IN_RESET = 3'h1,
    RSSS_SETTLE = 3'h2,
    RSSS_RUN = 3'h4
  } rsss_state_t;

  // one strobe-qualified bus access
  typedef struct packed {
    logic program_store_strobe;
    logic data_read_strobe;
    logic write_strobe;
    logic [2:0] io_addr;
    logic [7:0] wdata;
  } rsss_bus_t;

  // which array answers the current access
  typedef struct packed {
    logic eprom;
    logic sram;
    logic io;
  } rsss_select_t;

endpackage : rsss_pkg

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rsss_pkg::*;
  logic core_clk_i = 0, reset_i = 1, lv = 0, eith = 0, both = 0, csi = 0, iosel = 0, valid, pd;
  logic [2:0] cseq = 3'h5, addr = 0, cs, oe, hoe;
  logic [1:0] kind = 0;
  logic [7:0] wd = 0, rd, power_mode_register, mem [8];
  rsss_bus_t bus;
  rsss_select_t sel;
  int num_errors = 0, num_checks = 0, seed = 61, n, n0;
  always #5 core_clk_i = ~core_clk_i;
  rsss_mcu u_mcu (.core_clk_i, .kind_i(kind), .addr_i(addr), .wdata_i(wd), .bus_o(bus));
  rsss_core dut (.core_clk_i, .reset_i, .low_voltage_variant_i(lv), .upper_cs_push_pull_i(1'b1),
    .eprom_either_strobe_i(eith), .sram_both_spaces_i(both), .chip_select_in_i(csi), .bus_i(bus),
    .io_register_space_select_i(iosel), .cs_equation_i(cseq), .high_address_inputs_i(addr),
    .upper_chip_select_outputs_o(cs), .port_c_pins_oe_o(oe), .high_address_inputs_oe_o(hoe),
    .signals_valid_o(valid), .power_down_o(pd), .select_o(sel), .io_rdata_o(rd), .power_mode_register_o(power_mode_register));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic op(input logic [1:0] k, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    kind <= k;
    addr <= a;
    wd <= d;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : op
  task automatic rst();
    reset_i = 1;
    repeat (16) @(negedge core_clk_i);
    chk({5'h0, cs}, 8'h07);
    chk({5'h0, oe}, 8'h00);
    chk({5'h0, hoe}, 8'h00);
    chk(power_mode_register, 8'h00);
    reset_i = 0;
    n = 0;
    while (valid !== 1'b1 && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    $display("reset test done");
  endtask : rst
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    rst();
    n0 = n;
    for (int k = 0; k < 12; k++) begin
      eith = $random(seed);
      both = $random(seed);
      op(k % 4, 3'h0, 8'h00);
      chk({5'h0, sel}, {5'h0, k % 4 == 1 || eith && k % 4 == 2, k % 4 > 1 || both && k % 4 == 1, 1'b0});
    end
    $display("space test done");
    iosel = 1;
    for (int i = 0; i < 8; i++) begin
      mem[i] = $random(seed);
      op(2'h3, i, mem[i]);
    end
    for (int i = 0; i < 8; i++) begin
      op(2'h2, i, 8'h00);
      chk(rd, mem[i]);
      chk({5'h0, sel}, {5'h0, eith, 1'b1, 1'b1});
    end
    cseq = $random(seed);
    csi = 1;
    op(2'h3, 3'h7, ~mem[7]);
    op(2'h0, 3'h0, 8'h00);
    chk({5'h0, sel}, 8'h00);
    chk({7'h0, pd}, 8'h01);
    chk({5'h0, cs}, {5'h0, cseq});
    csi = 0;
    op(2'h2, 3'h7, 8'h00);
    chk(power_mode_register, mem[7]);
    $display("power-down test done");
    lv = 1;
    rst();
    chk(8'(n - n0), 8'h32);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
